/* design/from_flag_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module from_flag_eval (
  input wire logic [15:0] flags,
  input wire logic [3:0] sel,
  input wire logic negate,
  input wire logic [31:0] res_word,
  output logic cond,
  output logic res_zero,
  output logic res_gt,
  output logic res_lt
);

  always_comb begin
    // outcome depends only on the selected bit as it stands now
    cond = flags[sel] ^ negate; // RULE7 RULE12
    res_zero = (res_word == 32'h0000_0000); // RULE4
    res_lt = res_word[31]; // RULE4
    res_gt = !res_zero && !res_word[31]; // RULE4
  end

endmodule : from_flag_eval
`default_nettype wire

/* design/from_flag_unit.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: a sixteen-bit flag register is kept and tested by conditional transfers.
// RULE2: eight bits follow machine status; the other eight change only by program.
// RULE3: bits: always-true, zero, greater, less, carry, overflow, busy, enable, eight program.
// RULE4: zero flag set exactly on zero result; sign flags follow result sign.
// RULE5: arithmetic flags except overflow are recomputed after each instruction; program may set.
// RULE6: overflow stays set until a program test of it clears it. Here a bus write to the flag register with bit 5 clear also clears it.
// RULE7: test-and-transfer outcome comes only from the selected flag bit.
// RULE8: save modifier on arithmetic or shift copies accumulator before execution.
// RULE9: save copy holds main word, exponent, fraction and extension together.
// RULE10: floating operations normalize unless the unnormalized modifier is given.
// RULE11: unnormalized modifier accepted everywhere, no effect on compare or store classes.
// RULE12: negate modifier makes the action happen when the flag is clear.
// RULE13: in link and jump, only transfer is conditional; set, reset, trigger always happen.
// RULE14: always-true bit reads one and ignores every write.
// RULE15: save holds pre-instruction accumulator while flags show the post-instruction result.
module from_flag_unit (
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire from_pkg::from_acc_t acc,
  input wire from_pkg::from_instr_t instr,
  input wire from_pkg::from_result_t result,
  input wire from_pkg::from_flag_op_t flag_op,
  input wire logic chan_busy,
  input wire logic int_enable,
  output logic [15:0] flags_out,
  output logic xfer_valid,
  output logic xfer_take,
  output from_pkg::from_kind_t xfer_kind,
  output logic norm_en,
  output from_pkg::from_acc_t save_out
);

  from_pkg::from_state_t st_r;
  from_pkg::from_state_t st_nxt;
  logic cond;
  logic res_zero;
  logic res_gt;
  logic res_lt;

  from_flag_eval u_eval (
    .flags(st_r.flags),
    .sel(flag_op.sel),
    .negate(flag_op.negate),
    .res_word(result.word),
    .cond(cond),
    .res_zero(res_zero),
    .res_gt(res_gt),
    .res_lt(res_lt)
  );

  // one write and one read in flight; a new address is refused while a response waits
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  assign flags_out = st_r.flags;
  assign xfer_valid = st_r.xfer_valid;
  assign xfer_take = st_r.xfer_take;
  assign xfer_kind = st_r.xfer_kind;
  assign norm_en = st_r.norm_en;
  assign save_out = st_r.save;

  function automatic logic [31:0] read_mux(input from_pkg::from_state_t s,
                                           input logic [7:0] addr,
                                           output logic hit);
    logic [31:0] d;
    d = 32'h0000_0000;
    hit = 1'b1;
    case ({addr[7:2], 2'b00})
      from_pkg::OFS_FLAGS: begin
        d[15:0] = s.flags;
      end
      from_pkg::OFS_SAVE_MAIN: begin
        d = s.save.main_word;
      end
      from_pkg::OFS_SAVE_EXP: begin
        d = s.save.acc_exponent_part;
      end
      from_pkg::OFS_SAVE_FRAC: begin
        d = s.save.acc_fraction_part;
      end
      from_pkg::OFS_SAVE_EXT: begin
        d = s.save.ext_word;
      end
      from_pkg::OFS_STATUS: begin
        d[from_pkg::ST_XFER_TAKE] = s.xfer_take;
        d[from_pkg::ST_NORM_EN] = s.norm_en;
        d[from_pkg::ST_SAVE_VALID] = s.save_valid;
        d[from_pkg::ST_UNNORM_SEEN] = s.unnorm_seen;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return d;
  endfunction : read_mux

  always_comb begin
    logic [15:0] wmask;
    logic [15:0] bit_sel;
    logic rd_hit;
    logic [31:0] rd_data;
    wmask = 16'h0000;
    bit_sel = 16'h0000;
    rd_hit = 1'b0;
    rd_data = 32'h0000_0000;
    st_nxt = st_r;

    // status bits follow the machine every cycle
    st_nxt.flags[from_pkg::BIT_BUSY] = chan_busy; // RULE2 RULE3
    st_nxt.flags[from_pkg::BIT_INTEN] = int_enable; // RULE2 RULE3

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = from_pkg::RESP_OKAY;
      case ({st_r.awaddr[7:2], 2'b00})
        from_pkg::OFS_FLAGS: begin
          wmask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}} & from_pkg::FLAGS_PROG_MASK;
          st_nxt.flags = (st_nxt.flags & ~wmask) | (st_r.wdata[15:0] & wmask); // RULE5 RULE14
        end
        // read-only registers accept and drop the data
        from_pkg::OFS_SAVE_MAIN, from_pkg::OFS_SAVE_EXP, from_pkg::OFS_SAVE_FRAC,
        from_pkg::OFS_SAVE_EXT, from_pkg::OFS_STATUS: begin
          st_nxt.bresp = from_pkg::RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = from_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel answers one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rd_data = read_mux(st_r, s_axi_araddr, rd_hit);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_data;
      st_nxt.rresp = rd_hit ? from_pkg::RESP_OKAY : from_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // flag test-and-transfer; instruction effects override a colliding bus write
    st_nxt.xfer_valid = 1'b0;
    if (flag_op.valid) begin
      st_nxt.xfer_valid = 1'b1;
      st_nxt.xfer_take = cond; // RULE7 RULE12 RULE13
      st_nxt.xfer_kind = flag_op.kind;
      bit_sel = 16'h0001 << flag_op.sel;
      // testing overflow is the program's way to clear it
      if (flag_op.sel == from_pkg::BIT_OVF) begin
        st_nxt.flags[from_pkg::BIT_OVF] = 1'b0; // RULE6
      end
      // modification is unconditional; fixed bits are not in the mask
      bit_sel = bit_sel & from_pkg::FLAGS_PROG_MASK; // RULE2 RULE14
      case (flag_op.act)
        from_pkg::FROM_ACT_SET: begin
          st_nxt.flags = st_nxt.flags | bit_sel; // RULE13
        end
        from_pkg::FROM_ACT_RESET: begin
          st_nxt.flags = st_nxt.flags & ~bit_sel; // RULE13
        end
        from_pkg::FROM_ACT_TRIGGER: begin
          st_nxt.flags = st_nxt.flags ^ bit_sel; // RULE13
        end
        default: begin
          st_nxt.flags = st_nxt.flags;
        end
      endcase
    end

    // save and normalization are decided as the instruction starts,
    // so the copy holds the accumulator from before it runs
    if (instr.start) begin
      if (instr.save_mod && instr.arith_or_shift) begin
        st_nxt.save = acc; // RULE8 RULE9 RULE15
        st_nxt.save_valid = 1'b1;
      end
      // compare and store classes never normalize, so the modifier is moot there
      st_nxt.norm_en = instr.float_op && !instr.no_norm_class && !instr.unnorm_mod; // RULE10 RULE11
      st_nxt.unnorm_seen = instr.float_op && instr.unnorm_mod; // RULE11
    end

    // result flags land after the instruction; an overflow beats any same-cycle clear
    if (result.done) begin
      if (result.upd_arith) begin
        st_nxt.flags = st_nxt.flags & ~from_pkg::FLAGS_ARITH_MASK; // RULE5
        st_nxt.flags[from_pkg::BIT_ZERO] = res_zero; // RULE4 RULE15
        st_nxt.flags[from_pkg::BIT_GT] = res_gt; // RULE4
        st_nxt.flags[from_pkg::BIT_LT] = res_lt; // RULE4
        st_nxt.flags[from_pkg::BIT_CARRY] = result.carry; // RULE5
      end
      if (result.ovf) begin
        st_nxt.flags[from_pkg::BIT_OVF] = 1'b1; // RULE6
      end
    end

    st_nxt.flags[from_pkg::BIT_ALWAYS] = 1'b1; // RULE14 RULE1
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= from_pkg::ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : from_flag_unit
`default_nettype wire

/* design/from_pkg.sv */
package from_pkg;

  // flag register layout: bits 0..7 follow machine status, 8..15 are program flags
  localparam int FLAG_W = 16;
  localparam int FLAG_SEL_W = 4;
  localparam int BIT_ALWAYS = 0;
  localparam int BIT_ZERO = 1;
  localparam int BIT_GT = 2;
  localparam int BIT_LT = 3;
  localparam int BIT_CARRY = 4;
  localparam int BIT_OVF = 5;
  localparam int BIT_BUSY = 6;
  localparam int BIT_INTEN = 7;
  localparam int BIT_PROG0 = 8;

  localparam logic [FLAG_W-1:0] FLAGS_RST = 16'h0001;
  // bits software and flag instructions may change; always-true, busy and enable excluded
  localparam logic [FLAG_W-1:0] FLAGS_PROG_MASK = 16'hff3e;
  // arithmetic bits recomputed after every instruction (overflow is sticky instead)
  localparam logic [FLAG_W-1:0] FLAGS_ARITH_MASK = 16'h001e;

  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SAVE_MAIN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SAVE_EXP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SAVE_FRAC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SAVE_EXT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // status register bit positions
  localparam int ST_XFER_TAKE = 0;
  localparam int ST_NORM_EN = 1;
  localparam int ST_SAVE_VALID = 2;
  localparam int ST_UNNORM_SEEN = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FROM_ACT_NONE = 2'h0,
    FROM_ACT_SET = 2'h1,
    FROM_ACT_RESET = 2'h2,
    FROM_ACT_TRIGGER = 2'h3
  } from_act_t;

  typedef enum logic [3:0] {
    FROM_KIND_HALT_JUMP = 4'h1,
    FROM_KIND_EXEC = 4'h2,
    FROM_KIND_LINK = 4'h4,
    FROM_KIND_JUMP = 4'h8
  } from_kind_t;

  // the four accumulator component registers
  typedef struct packed {
    logic [WORD_W-1:0] main_word;
    logic [WORD_W-1:0] acc_exponent_part;
    logic [WORD_W-1:0] acc_fraction_part;
    logic [WORD_W-1:0] ext_word;
  } from_acc_t;

  // decoded instruction at the moment it starts
  typedef struct packed {
    logic start;
    logic save_mod;
    logic unnorm_mod;
    logic arith_or_shift;
    logic float_op;
    logic no_norm_class;
  } from_instr_t;

  // result of an executed instruction
  typedef struct packed {
    logic done;
    logic upd_arith;
    logic [WORD_W-1:0] word;
    logic carry;
    logic ovf;
  } from_result_t;

  // flag test-and-transfer request
  typedef struct packed {
    logic valid;
    from_kind_t kind;
    logic [FLAG_SEL_W-1:0] sel;
    logic negate;
    from_act_t act;
  } from_flag_op_t;

  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    from_acc_t save;
    logic save_valid;
    logic xfer_valid;
    logic xfer_take;
    from_kind_t xfer_kind;
    logic norm_en;
    logic unnorm_seen;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [WORD_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [WORD_W-1:0] rdata;
    logic [1:0] rresp;
  } from_state_t;

  localparam from_state_t ST_RST = '{flags: FLAGS_RST, xfer_kind: FROM_KIND_JUMP, default: '0};

endpackage : from_pkg

/* test/from_flag_unit_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module from_flag_unit_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire from_pkg::from_acc_t acc,
  input wire from_pkg::from_instr_t instr,
  input wire from_pkg::from_result_t result,
  input wire from_pkg::from_flag_op_t flag_op,
  input wire logic chan_busy,
  input wire logic int_enable,
  input wire logic [15:0] flags_out,
  input wire logic xfer_valid,
  input wire logic xfer_take,
  input wire logic norm_en,
  input wire from_pkg::from_acc_t save_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence save_req;
    instr.start && instr.save_mod && instr.arith_or_shift;
  endsequence
  sequence arith_done;
    result.done && result.upd_arith;
  endsequence
  // readies high means no write is pending, so only a flag op could clear overflow
  sequence quiet_ovf;
    flags_out[5] && !flag_op.valid && s_axi_awready && s_axi_wready;
  endsequence

  a_always_one: assert property (flags_out[0])
    else $error("always bit low");
  a_xfer_pulse: assert property ($past(aresetn) |-> xfer_valid == $past(flag_op.valid))
    else $error("xfer pulse wrong");
  a_take_from_bit: assert property (flag_op.valid |=>
    xfer_take == ($past(flags_out[flag_op.sel]) ^ $past(flag_op.negate)))
    else $error("take decision wrong");
  a_save_copy: assert property (save_req |=> save_out == $past(acc))
    else $error("save copy wrong");
  a_norm_choice: assert property (instr.start |=> norm_en ==
    $past(instr.float_op && !instr.no_norm_class && !instr.unnorm_mod))
    else $error("normalize enable wrong");
  a_zero_sign: assert property (arith_done |=>
    flags_out[1] == ($past(result.word) == 32'h0) && flags_out[3] == $past(result.word[31]))
    else $error("zero or sign flag wrong");
  a_ovf_sticky: assert property (quiet_ovf |=> flags_out[5])
    else $error("overflow dropped");
  a_ovf_set: assert property (result.done && result.ovf |=> flags_out[5])
    else $error("overflow not set");
  a_status_copy: assert property ($past(aresetn) |->
    flags_out[7:6] == $past({int_enable, chan_busy}))
    else $error("status bits wrong");
  a_act_uncond: assert property (flag_op.valid && flag_op.act == from_pkg::FROM_ACT_SET &&
    flag_op.sel[3] && s_axi_awready && s_axi_wready |=> flags_out[$past(flag_op.sel)])
    else $error("set not applied");
endmodule : from_flag_unit_chk

bind from_flag_unit from_flag_unit_chk u_from_flag_unit_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .acc, .instr, .result, .flag_op, .chan_busy, .int_enable, .flags_out,
  .xfer_valid, .xfer_take, .norm_en, .save_out);

`default_nettype wire

/* test/from_flag_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module from_flag_unit_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic chan_busy, int_enable, xfer_valid, xfer_take, norm_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] flags_out;
  from_pkg::from_acc_t acc, save_out, ea;
  from_pkg::from_instr_t instr;
  from_pkg::from_result_t result;
  from_pkg::from_flag_op_t flag_op;
  from_pkg::from_kind_t xfer_kind;
  logic [31:0] wv [3] = '{32'h0, 32'h5, 32'h80000000};
  int miscompares, n_tests;

  from_flag_unit u_from_flag_unit (.*);

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  task results;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task chk(input logic [127:0] s, input logic [127:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : axw

  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask : axr

  // acc flips on the edge after start, so a late capture shows up in save_out
  task ins(input logic [5:0] i, input logic [35:0] r);
    @(posedge aclk);
    instr <= i;
    result <= r;
    @(posedge aclk);
    instr <= '0;
    result <= '0;
    acc <= ~acc;
    #1;
  endtask : ins

  task fop(input from_pkg::from_kind_t k, input logic [3:0] s, input logic n,
           input from_pkg::from_act_t a, input logic t);
    @(posedge aclk);
    flag_op <= '{1'h1, k, s, n, a};
    @(posedge aclk);
    flag_op.valid <= 1'h0;
    #1;
    chk(xfer_valid, 1'h1);
    chk(xfer_take, t);
    chk(xfer_kind, k);
  endtask : fop

  // whole sequence needs under 100 cycles; the 4000-cycle limit leaves ample slack
  initial begin
    #20000;
    miscompares++;
    results;
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, int_enable} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {acc, instr, result, flag_op, miscompares, n_tests} = '0;
    chan_busy = 1'h1;
    s_axi_wstrb = 4'hf;
    aresetn = 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    axr(from_pkg::OFS_FLAGS, 32'h41, from_pkg::RESP_OKAY);
    axr(from_pkg::OFS_STATUS, 32'h0, from_pkg::RESP_OKAY);
    axr(8'h18, 32'h0, from_pkg::RESP_SLVERR);
    axw(8'h18, 32'hffffffff, from_pkg::RESP_SLVERR);
    axw(from_pkg::OFS_FLAGS, 32'hffff, from_pkg::RESP_OKAY);
    axr(from_pkg::OFS_FLAGS, 32'hff7f, from_pkg::RESP_OKAY);
    int_enable <= 1'h1;
    chan_busy <= 1'h0;
    axw(from_pkg::OFS_FLAGS, 32'h0, from_pkg::RESP_OKAY);
    axr(from_pkg::OFS_FLAGS, 32'h81, from_pkg::RESP_OKAY);
    $display("end of register test");
    for (int k = 0; k < 3; k++) begin
      ins(6'h0, {2'h3, wv[k], k[0], 1'h0});
      chk(flags_out, {8'h0, 3'h4, k[0], wv[k][31], (wv[k] != 32'h0 && !wv[k][31]),
          (wv[k] == 32'h0), 1'h1});
    end
    ins(6'h0, {2'h3, 32'h1, 1'h0, 1'h1});
    chk(flags_out[5:1], 5'h12);
    ins(6'h0, {2'h3, 32'h0, 2'h0});
    chk(flags_out[5:1], 5'h11);
    fop(from_pkg::FROM_KIND_JUMP, 4'h5, 1'h0, from_pkg::FROM_ACT_NONE, 1'h1);
    chk(flags_out[5], 1'h0);
    $display("end of arithmetic test");
    fop(from_pkg::FROM_KIND_EXEC, 4'h9, 1'h1, from_pkg::FROM_ACT_TRIGGER, 1'h1);
    chk(flags_out[9], 1'h1);
    fop(from_pkg::FROM_KIND_LINK, 4'h9, 1'h0, from_pkg::FROM_ACT_RESET, 1'h1);
    chk(flags_out[9], 1'h0);
    fop(from_pkg::FROM_KIND_JUMP, 4'h9, 1'h0, from_pkg::FROM_ACT_SET, 1'h0);
    chk(flags_out[9], 1'h1);
    fop(from_pkg::FROM_KIND_HALT_JUMP, 4'h9, 1'h1, from_pkg::FROM_ACT_NONE, 1'h0);
    chk(flags_out[9], 1'h1);
    fop(from_pkg::FROM_KIND_JUMP, 4'h0, 1'h0, from_pkg::FROM_ACT_RESET, 1'h1);
    chk(flags_out[0], 1'h1);
    $display("end of flag test");
    ea = {32'h11111111, 32'h22222222, 32'h33333333, 32'h44444444};
    @(posedge aclk);
    acc <= ea;
    ins(6'h34, {2'h3, 32'h0, 2'h0});
    chk(save_out, ea);
    chk(flags_out[1], 1'h1);
    axr(from_pkg::OFS_SAVE_EXP, 32'h22222222, from_pkg::RESP_OKAY);
    axr(from_pkg::OFS_SAVE_EXT, 32'h44444444, from_pkg::RESP_OKAY);
    ins(6'h24, 36'h0);
    chk(save_out, ea);
    $display("end of save test");
    ins(6'h22, 36'h0);
    chk(norm_en, 1'h1);
    ins(6'h2a, 36'h0);
    chk(norm_en, 1'h0);
    // last take was the always bit, a save is held and the modifier was seen
    axr(from_pkg::OFS_STATUS, 32'hd, from_pkg::RESP_OKAY);
    ins(6'h23, 36'h0);
    chk(norm_en, 1'h0);
    $display("end of normalize test");
    results;
  end
endmodule : from_flag_unit_tb_top

`default_nettype wire
